// File: hdl/gpco_port.sv
// One GPIO port: direction, drive, pull-up, input clamp and overrides.
// Assumes a register master on clock and pads resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
`include "gpco_regs.svh"
module gpco_port
  import gpco_pkg::*;
#(
  parameter int WIDTH = `GPCO_WIDTH
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Register port
  input  wire logic [`GPCO_ADDR_W-1:0] reg_addr,
  input  wire logic [WIDTH-1:0]       reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output var  logic [WIDTH-1:0]       reg_rdata,
  // Pads
  input  wire logic [WIDTH-1:0]       pad_in,
  output var  logic [WIDTH-1:0]       pad_out,
  output var  logic [WIDTH-1:0]       pad_oe_n,
  output var  logic [WIDTH-1:0]       pullup_en,
  // Alternate function overrides
  input  wire logic [WIDTH-1:0]       pullup_override_enable,
  input  wire logic [WIDTH-1:0]       pullup_override_value,
  input  wire logic [WIDTH-1:0]       dir_override_enable,
  input  wire logic [WIDTH-1:0]       dir_override_value,
  input  wire logic [WIDTH-1:0]       outval_override_enable,
  input  wire logic [WIDTH-1:0]       outval_override_value,
  input  wire logic [WIDTH-1:0]       toggle_override_enable,
  input  wire logic [WIDTH-1:0]       input_en_override_enable,
  input  wire logic [WIDTH-1:0]       input_en_override_value,
  output var  logic [WIDTH-1:0]       alt_func_input,
  // Sleep and external interrupts
  input  wire logic                   sleep,
  input  wire logic [WIDTH-1:0]       ext_int_en,
  input  wire logic [WIDTH-1:0]       ext_int_edge_cfg,
  output var  logic [WIDTH-1:0]       ext_int_flag_set
);

  if (WIDTH < 1 || WIDTH > `GPCO_MAX_WIDTH) begin : g_chk
    $error("gpco_port: WIDTH out of range");
  end

  typedef struct packed {
    logic [WIDTH-1:0] drive;
    logic [WIDTH-1:0] dir;
    logic             global_pullup_disable;
    logic [WIDTH-1:0] rdata;
    logic [WIDTH-1:0] pad_out;
    logic [WIDTH-1:0] pad_oe_n;
    logic [WIDTH-1:0] pullup_en;
    logic             sleep_q;
    logic [WIDTH-1:0] wake_pend1;
    logic [WIDTH-1:0] wake_pend2;
    logic [WIDTH-1:0] int_flag;
  } gpco_state_t;

  gpco_state_t      st;
  gpco_state_t      next_st;
  logic [WIDTH-1:0] input_en;
  logic [WIDTH-1:0] clamp_mask;
  logic [WIDTH-1:0] pin_input_bit;
  logic [WIDTH-1:0] drv_en;
  logic [WIDTH-1:0] toggled;

  function automatic logic [WIDTH-1:0] pu_calc(
    input logic [WIDTH-1:0] dir,
    input logic [WIDTH-1:0] drive,
    input logic             global_pullup_disable,
    input logic [WIDTH-1:0] ovr_en,
    input logic [WIDTH-1:0] ovr_val
  );
    logic [WIDTH-1:0] normal;
    normal = ~dir & drive & {WIDTH{~global_pullup_disable}};
    return (ovr_en & ovr_val) | (~ovr_en & normal);
  endfunction : pu_calc

  // Input enable and clamp, ahead of the synchronizer
  always_comb begin
    clamp_mask = {WIDTH{sleep}} & ~ext_int_en;
    input_en = (input_en_override_enable & input_en_override_value)
             | (~input_en_override_enable & ~clamp_mask);
    alt_func_input = pad_in & input_en;
  end

  gpco_pin_sync #(
    .WIDTH (WIDTH)
  ) u_sync (
    .clock     (clock),
    .rst       (rst),
    .pad_level (alt_func_input),
    .pin_level (pin_input_bit)
  );

  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    toggled = '0;
    if (reg_wr) begin
      unique case (gpco_reg_t'(reg_addr))
        GPCO_PIN:   toggled = reg_wdata;
        GPCO_DIR:   next_st.dir = reg_wdata;
        GPCO_DRIVE: next_st.drive = reg_wdata;
        GPCO_CTRL:  next_st.global_pullup_disable = reg_wdata[`GPCO_PUD_BIT];
      endcase
    end
    next_st.drive = next_st.drive ^ toggled
                  ^ toggle_override_enable;
    if (reg_rd) begin
      unique case (gpco_reg_t'(reg_addr))
        GPCO_PIN:   next_st.rdata = pin_input_bit;
        GPCO_DIR:   next_st.rdata = st.dir;
        GPCO_DRIVE: next_st.rdata = st.drive;
        GPCO_CTRL:  next_st.rdata[`GPCO_PUD_BIT] = st.global_pullup_disable;
      endcase
    end
    // Pads follow the new register values so a write reaches them at once
    drv_en = (dir_override_enable & dir_override_value)
           | (~dir_override_enable & next_st.dir);
    next_st.pad_oe_n = ~drv_en;
    next_st.pad_out = drv_en
      & ((outval_override_enable & outval_override_value)
       | (~outval_override_enable & next_st.drive));
    next_st.pullup_en = pu_calc(next_st.dir, next_st.drive,
                                next_st.global_pullup_disable, pullup_override_enable,
                                pullup_override_value);
    // Clamp released on wake gives a rise that an edge trigger sees
    next_st.sleep_q = sleep;
    next_st.wake_pend1 = {WIDTH{st.sleep_q & ~sleep}}
                       & ~ext_int_en & ext_int_edge_cfg
                       & ~input_en_override_enable;
    next_st.wake_pend2 = st.wake_pend1;
    next_st.int_flag = st.wake_pend2 & pin_input_bit;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.pad_oe_n <= '1;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    reg_rdata = st.rdata;
    pad_out = st.pad_out;
    pad_oe_n = st.pad_oe_n;
    pullup_en = st.pullup_en;
    ext_int_flag_set = st.int_flag;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_pullup_calc: assert property (
    ##1 pullup_en == pu_calc(st.dir, st.drive, st.global_pullup_disable,
      $past(pullup_override_enable), $past(pullup_override_value))
  ) else $error("pull-up enable mismatch");

  a_reset_release: assert property (
    $fell(rst) |-> (&pad_oe_n) && (pullup_en == '0)
  ) else $error("pads not tri-stated out of reset");

  a_oe_follow: assert property (
    ##1 pad_oe_n == ~(($past(dir_override_enable)
      & $past(dir_override_value))
      | (~$past(dir_override_enable) & st.dir))
  ) else $error("driver enable mismatch");

  a_out_value: assert property (
    ##1 (pad_out & ~pad_oe_n) == (~pad_oe_n
      & (($past(outval_override_enable) & $past(outval_override_value))
       | (~$past(outval_override_enable) & st.drive)))
  ) else $error("driven value mismatch");

  a_pin_toggle: assert property (
    reg_wr && reg_addr == `GPCO_OFS_PIN |=>
      st.drive == ($past(st.drive) ^ $past(reg_wdata)
                   ^ $past(toggle_override_enable))
  ) else $error("pin write toggle wrong");

  a_read_dir: assert property (
    reg_rd && reg_addr == `GPCO_OFS_DIR |=> reg_rdata == $past(st.dir)
  ) else $error("direction read-back wrong");

  a_clamp_low: assert property (
    ##2 (pin_input_bit & $past(clamp_mask & ~input_en_override_enable)
         & $past(clamp_mask & ~input_en_override_enable, 2)) == '0
  ) else $error("clamped input read high");

  a_wake_flag: assert property (
    |ext_int_flag_set |-> !$past(sleep, 3) && $past(sleep, 4)
  ) else $error("wake flag without wake");

  // Register port: read slot, read-back and write landing
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == '0
  ) else $error("read data outside read slot");

  a_read_drive: assert property (
    reg_rd && reg_addr == `GPCO_OFS_DRIVE |=>
      reg_rdata == $past(st.drive)
  ) else $error("drive read-back wrong");

  a_read_pin: assert property (
    reg_rd && reg_addr == `GPCO_OFS_PIN |=>
      reg_rdata == $past(pin_input_bit)
  ) else $error("pin read-back wrong");

  a_read_ctrl: assert property (
    reg_rd && reg_addr == `GPCO_OFS_CTRL |=>
      reg_rdata[`GPCO_PUD_BIT] == $past(st.global_pullup_disable)
  ) else $error("control read-back wrong");

  a_dir_write: assert property (
    reg_wr && reg_addr == `GPCO_OFS_DIR |=>
      st.dir == $past(reg_wdata)
  ) else $error("direction write lost");

  a_drive_write: assert property (
    reg_wr && reg_addr == `GPCO_OFS_DRIVE |=>
      st.drive == ($past(reg_wdata) ^ $past(toggle_override_enable))
  ) else $error("drive write lost");

  a_ctrl_write: assert property (
    reg_wr && reg_addr == `GPCO_OFS_CTRL |=>
      st.global_pullup_disable == $past(reg_wdata[`GPCO_PUD_BIT])
  ) else $error("pull-up disable write lost");

  // Register contents hold unless written or toggled
  a_dir_hold: assert property (
    !(reg_wr && reg_addr == `GPCO_OFS_DIR) |=>
      st.dir == $past(st.dir)
  ) else $error("direction changed unwritten");

  a_toggle_hold: assert property (
    !reg_wr |=>
      st.drive == ($past(st.drive) ^ $past(toggle_override_enable))
  ) else $error("drive changed without toggle");

  a_pud_hold: assert property (
    !(reg_wr && reg_addr == `GPCO_OFS_CTRL) |=> $stable(st.global_pullup_disable)
  ) else $error("pull-up disable changed unwritten");

  // Pad driver and pull-up
  a_tristate_low: assert property (
    (pad_out & pad_oe_n) == '0
  ) else $error("undriven pad shows a high value");

  a_pu_off_drv: assert property (
    (pullup_en & ~$past(pullup_override_enable) & st.dir) == '0
  ) else $error("pull-up on an output pin");

  a_pud_blocks: assert property (
    (pullup_en & ~$past(pullup_override_enable)
      & {WIDTH{st.global_pullup_disable}}) == '0
  ) else $error("pull-up on while globally disabled");

  a_pu_override: assert property (
    !$past(rst) |-> (pullup_en & $past(pullup_override_enable))
      == ($past(pullup_override_enable) & $past(pullup_override_value))
  ) else $error("pull-up override ignored");

  a_oe_override: assert property (
    !$past(rst) |-> (~pad_oe_n & $past(dir_override_enable))
      == ($past(dir_override_enable) & $past(dir_override_value))
  ) else $error("direction override ignored");

  a_out_override: assert property (
    !$past(rst) |-> (pad_out & $past(outval_override_enable))
      == (~pad_oe_n & $past(outval_override_enable)
          & $past(outval_override_value))
  ) else $error("output value override ignored");

  // Digital input enable, clamp and alternate input
  a_alt_input: assert property (
    (alt_func_input & ~pad_in) == '0
  ) else $error("alternate input high on a low pad");

  a_input_ovr: assert property (
    (input_en_override_enable & input_en_override_value
      & (alt_func_input ^ pad_in)) == '0
  ) else $error("forced input enable not passing pad");

  a_input_off: assert property (
    (input_en_override_enable & ~input_en_override_value
      & alt_func_input) == '0
  ) else $error("forced input disable not clamping");

  a_wake_clamp: assert property (
    (~input_en_override_enable & ext_int_en
      & (alt_func_input ^ pad_in)) == '0
  ) else $error("interrupt pin clamped in sleep");

  a_sleep_clamp: assert property (
    sleep |-> (~input_en_override_enable & ~ext_int_en
      & alt_func_input) == '0
  ) else $error("input not clamped in sleep");

  a_awake_pass: assert property (
    !sleep |-> (~input_en_override_enable
      & (alt_func_input ^ pad_in)) == '0
  ) else $error("input clamped while awake");

  // Synchronizer delay: one catch half cycle, then the pin register
  a_sync_delay: assert property (
    !$past(rst) |-> pin_input_bit == $past(alt_func_input)
  ) else $error("pin input bit not one cycle behind");

  // Wake flag only for configured, disabled, high pins
  a_flag_cfg: assert property (
    (ext_int_flag_set & ($past(ext_int_en, 3)
      | ~$past(ext_int_edge_cfg, 3))) == '0
  ) else $error("wake flag on an unqualified pin");

  a_flag_pin: assert property (
    (ext_int_flag_set & ~$past(pin_input_bit)) == '0
  ) else $error("wake flag on a low pin");

  a_flag_pulse: assert property (
    ext_int_flag_set != '0 |=> ext_int_flag_set == '0
  ) else $error("wake flag longer than one cycle");

  // Values seen on the first edge after reset
  a_reset_values: assert property (
    $fell(rst) |-> st.dir == '0 && st.drive == '0
      && pad_out == '0 && reg_rdata == '0
  ) else $error("registers not cleared by reset");

endmodule : gpco_port
`default_nettype wire

// File: hdl/gpco_regs.svh
// Register offsets, field positions and reset values of the GPIO port.
// Assumes it is included by the package and the port module.
`ifndef GPCO_REGS_SVH
`define GPCO_REGS_SVH
`define GPCO_ADDR_W     2
`define GPCO_OFS_PIN    2'h0
`define GPCO_OFS_DIR    2'h1
`define GPCO_OFS_DRIVE  2'h2
`define GPCO_OFS_CTRL   2'h3
`define GPCO_PUD_BIT    0
`define GPCO_RST_DIR    1'b0
`define GPCO_RST_DRIVE  1'b0
`define GPCO_RST_PUD    1'b0
`define GPCO_WIDTH      8
`define GPCO_MAX_WIDTH  32
`endif

// File: hdl/gpco_pkg.sv
// Types shared by the GPIO port files.
// Assumes gpco_regs.svh sits beside it.
`include "gpco_regs.svh"
package gpco_pkg;
  typedef enum logic [`GPCO_ADDR_W-1:0] {
    GPCO_PIN   = `GPCO_OFS_PIN,
    GPCO_DIR   = `GPCO_OFS_DIR,
    GPCO_DRIVE = `GPCO_OFS_DRIVE,
    GPCO_CTRL  = `GPCO_OFS_CTRL
  } gpco_reg_t;
endpackage : gpco_pkg

// File: hdl/gpco_pin_sync.sv
// Pin level synchronizer: falling-edge catch then rising-edge register.
// Assumes pad levels arrive asynchronously to clock.
`timescale 1ns/1ps
`default_nettype none
`include "gpco_regs.svh"
module gpco_pin_sync #(
  parameter int WIDTH = `GPCO_WIDTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] pad_level,
  output var  logic [WIDTH-1:0] pin_level
);
  logic [WIDTH-1:0] sync_latch;

  // Same value a high-transparent latch holds after the fall
  always_ff @(negedge clock or posedge rst) begin
    if (rst) begin
      sync_latch <= '0;
    end else begin
      sync_latch <= pad_level;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_level <= '0;
    end else begin
      pin_level <= sync_latch;
    end
  end
endmodule : gpco_pin_sync
`default_nettype wire

// File: dv/gpco_pads.sv
// Circuitry outside the port: pin driver, weak pull-up, outside source.
// Assumes the bench chooses which pads the outside source drives.
`timescale 1ns/1ps
`default_nettype none
module gpco_pads #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         clock,
  // Port side and outside source
  input  wire logic [W-1:0] pad_out,
  input  wire logic [W-1:0] pad_oe_n,
  input  wire logic [W-1:0] pullup_en,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output var  logic [W-1:0] level
);
  logic [W-1:0] drift = '0;
  // A floating pad toggles so a lost pull-up cannot pass by chance
  always @(posedge clock) drift <= ~drift;
  assign level = ~pad_oe_n & pad_out | pad_oe_n & (ext_en & ext_val
    | ~ext_en & (pullup_en | drift));
endmodule : gpco_pads
`default_nettype wire

// File: dv/tb_top.sv
// Bench for the GPIO port: registers, pads, read-back, sleep, overrides.
// Assumes gpco_pads stands for the circuitry outside the pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top
  import gpco_pkg::*;
;
  logic       clock = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, rd_d = 1'b0;
  logic       sleep = 1'b0, p;
  logic [1:0] addr = '0;
  logic [7:0] wd = '0, pu_oe = '0, pu_ov = '0, dd_oe = '0, dd_ov = '0;
  logic [7:0] pv_oe = '0, pv_ov = '0, tog = '0, ie_oe = '0, ie_ov = '0;
  logic [7:0] int_en = '0, ecfg = '0, ext_en = '0, ext_val = '0;
  logic [7:0] rdata, pad, pout, oe_n, pu, afi, flag, d, v, t, en, seen, xv;
  logic [7:0] expq[$];
  int         err_count = 0, total_checks = 0, seed = 2;
  gpco_port #(.WIDTH(8)) dut_u (
    .clock(clock), .rst(rst), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .pad_in(pad),
    .pad_out(pout), .pad_oe_n(oe_n), .pullup_en(pu),
    .pullup_override_enable(pu_oe), .pullup_override_value(pu_ov),
    .dir_override_enable(dd_oe), .dir_override_value(dd_ov),
    .outval_override_enable(pv_oe), .outval_override_value(pv_ov),
    .toggle_override_enable(tog), .input_en_override_enable(ie_oe),
    .input_en_override_value(ie_ov), .alt_func_input(afi), .sleep(sleep),
    .ext_int_en(int_en), .ext_int_edge_cfg(ecfg), .ext_int_flag_set(flag));
  gpco_pads #(.W(8)) pads_u (
    .clock(clock), .pad_out(pout), .pad_oe_n(oe_n), .pullup_en(pu),
    .ext_en(ext_en), .ext_val(ext_val), .level(pad));
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic wr(input logic [1:0] a, input logic [7:0] x);
    @(posedge clock);
    addr <= a;
    wd   <= x;
    wr_s <= 1'b1;
    rd_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    expq.push_back(e);
    addr <= a;
    wr_s <= 1'b0;
    rd_s <= 1'b1;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      wr_s <= 1'b0;
      rd_s <= 1'b0;
    end
  endtask : idle
  initial forever #25 clock = ~clock;
  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    conclude();
  end
  // Read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_d) begin
      xv = expq.pop_front();
      `CHK("rdata", xv, rdata)
    end
    rd_d <= rd_s;
  end
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    `CHK("oe_n", 8'hff, oe_n)
    rd(GPCO_DIR, '0);
    rd(GPCO_DRIVE, '0);
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      v = $random(seed);
      p = i[0];
      wr(GPCO_CTRL, {7'h00, p});
      wr(GPCO_DRIVE, v);
      wr(GPCO_DIR, d);
      ext_val <= $random(seed);
      ext_en  <= ~d;
      idle(1);
      rd(GPCO_PIN, d & v | ~d & ext_val);
      rd(GPCO_DIR, d);
      rd(GPCO_CTRL, {7'h00, p});
      wr(GPCO_DRIVE, ~v);
      idle(1);
      rd(GPCO_PIN, d & ~v | ~d & ext_val);
      t = $random(seed);
      wr(GPCO_PIN, t);
      rd(GPCO_DRIVE, ~v ^ t);
      v = ~v ^ t;
      @(negedge clock);
      `CHK("oe_n", ~d, oe_n)
      `CHK("pout", d & v, pout)
      `CHK("pu", p ? 8'h00 : ~d & v, pu)
      `CHK("afi", pad, afi)
      @(posedge clock);
      rd_s <= 1'b0;
      {pu_oe, pu_ov, dd_oe, dd_ov} <= $random(seed);
      {pv_oe, pv_ov} <= 16'($random(seed));
      @(posedge clock);
      @(negedge clock);
      en = dd_oe & dd_ov | ~dd_oe & d;
      `CHK("pu", pu_oe & pu_ov | ~pu_oe & ~d & v & {8{~p}}, pu)
      `CHK("oe_n", ~en, oe_n)
      `CHK("pout", en & (pv_oe & pv_ov | ~pv_oe & v), pout)
      t = $random(seed);
      @(posedge clock);
      {pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov} <= '0;
      tog <= t;
      @(posedge clock);
      tog <= '0;
      rd(GPCO_DRIVE, v ^ t);
      idle(1);
    end
    wr(GPCO_DRIVE, '0);
    wr(GPCO_DIR, '0);
    for (int i = 0; i < 6; i++) begin
      idle(1);
      sleep  <= i[0];
      ext_en <= '1;
      {ext_val, int_en, ie_oe, ie_ov} <= $random(seed);
      idle(2);
      en = ie_oe & ie_ov | ~ie_oe & ({8{~sleep}} | int_en);
      `CHK("afi", ext_val & en, afi)
      rd(GPCO_PIN, ext_val & en);
    end
    idle(1);
    {ext_val, int_en, ecfg} <= 24'($random(seed));
    ie_oe <= '0;
    sleep <= 1'b1;
    idle(3);
    sleep <= 1'b0;
    seen = '0;
    repeat (5) begin
      @(posedge clock);
      seen |= flag;
    end
    `CHK("flag", ext_val & ecfg & ~int_en, seen)
    wr(GPCO_CTRL, '0);
    wr(GPCO_DRIVE, 8'hff);
    wr(GPCO_DIR, 8'h0f);
    idle(1);
    @(negedge clock);
    `CHK("pu", 8'hf0, pu)
    rst <= 1'b1;
    #1;
    `CHK("pu", 8'h00, pu)
    `CHK("oe_n", 8'hff, oe_n)
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(GPCO_DRIVE, '0);
    rd(GPCO_CTRL, '0);
    idle(3);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
